/* rtl/lpsw_pkg.sv */
`default_nettype none
package lpsw_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CMD    = 12'h000;
  localparam logic [11:0] ADDR_STATE  = 12'h004;
  localparam logic [11:0] ADDR_ARB    = 12'h008;
  localparam logic [11:0] ADDR_INT    = 12'h00C;
  localparam logic [11:0] ADDR_CTRL   = 12'h010;

  // ==========================================================================
  // Command word fields
  localparam int CMD_LOCK_BIT   = 7;
  localparam int CMD_CCG_BIT    = 6;
  localparam int CMD_MCG_BIT    = 5;
  localparam int CMD_MODE_LSB   = 2;
  localparam int CMD_MODE_MSB   = 4;
  localparam int CMD_DIR_MSB    = 1;

  localparam logic [1:0] DIR_NONE  = 2'b00;
  localparam logic [1:0] DIR_EXIT  = 2'b01;
  localparam logic [1:0] DIR_ENTRY = 2'b10;

  localparam logic [2:0] MODE_APD = 3'b000;
  localparam logic [2:0] MODE_PPD = 3'b001;
  localparam logic [2:0] MODE_SR  = 3'b010;

  localparam logic [7:0] CMD_LOCK_ONLY = 8'b100_000_00;

  // ==========================================================================
  // Ownership encodings
  localparam logic [3:0] ARB_IDLE    = 4'b0000;
  localparam logic [3:0] ARB_SW      = 4'b0001;
  localparam logic [3:0] ARB_AUTO    = 4'b0011;
  localparam logic [3:0] ARB_SW_LOCK = 4'b1001;

  // ==========================================================================
  // Status and interrupt word fields
  localparam int STAT_VALID_BIT = 5;
  localparam int INT_DONE_BIT   = 9;

  // Low-power depth codes reported in status bits [4:0]
  localparam logic [4:0] LP_NONE    = 5'h00;
  localparam logic [4:0] LP_APD     = 5'h01;
  localparam logic [4:0] LP_PPD     = 5'h02;
  localparam logic [4:0] LP_SR      = 5'h03;
  localparam logic [4:0] LP_SR_MCG  = 5'h04;
  localparam logic [4:0] LP_SR_CCG  = 5'h05;

  // Engine sequencing time per transition
  localparam int SEQ_CYCLES = 8;

endpackage
`default_nettype wire

/* rtl/lpsw_cmd_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lpsw_cmd_if;
  logic       req;
  logic [4:0] target;
  logic       isExit;
  logic       done;
  logic [4:0] curState;
  modport ctrl (output req, output target, output isExit, input done, input curState);
  modport eng  (input req, input target, input isExit, output done, output curState);
endinterface
`default_nettype wire

/* rtl/lpsw_engine.sv */
`timescale 1ns/1ps
`default_nettype none
// Transition sequencer of the power-saving unit
module lpsw_engine #(
  parameter int SEQ = lpsw_pkg::SEQ_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  lpsw_cmd_if.eng   cmd
);
  logic [7:0] cnt_q;
  logic       busy_q;
  logic [4:0] tgt_q;
  logic [4:0] cur_q;
  logic       done_q;

  assign cmd.done     = done_q;
  assign cmd.curState = cur_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
      tgt_q  <= lpsw_pkg::LP_NONE;
      cur_q  <= lpsw_pkg::LP_NONE;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (cmd.req && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q  <= 8'(SEQ - 1);
        tgt_q  <= cmd.isExit ? lpsw_pkg::LP_NONE : cmd.target;
      end else if (busy_q) begin
        if (cnt_q == 8'h00) begin
          busy_q <= 1'b0;
          cur_q  <= tgt_q;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/lpsw_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lpsw_top (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        autoReq,
  input  wire logic        rowOpen,
  output logic             autoGrant,
  output logic             memClkGate,
  output logic             ctlClkGate
);

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] autoSync_q;
  logic [1:0] rowSync_q;
  wire        autoReqS = autoSync_q[1];
  wire        rowOpenS = rowSync_q[1];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      autoSync_q <= 2'b00;
      rowSync_q  <= 2'b00;
    end else begin
      autoSync_q <= {autoSync_q[0], autoReq};
      rowSync_q  <= {rowSync_q[0], rowOpen};
    end
  end

  // ==========================================================================
  // APB decode
  wire apbWr   = psel && penable && pwrite;
  wire apbRd   = psel && penable && !pwrite;
  wire hitCmd  = (paddr == lpsw_pkg::ADDR_CMD);
  wire hitSt   = (paddr == lpsw_pkg::ADDR_STATE);
  wire hitArb  = (paddr == lpsw_pkg::ADDR_ARB);
  wire hitInt  = (paddr == lpsw_pkg::ADDR_INT);
  wire hitCtrl = (paddr == lpsw_pkg::ADDR_CTRL);
  wire hitAny  = hitCmd || hitSt || hitArb || hitInt || hitCtrl;
  wire cmdWr   = apbWr && hitCmd;
  wire intWr   = apbWr && hitInt;

  // ==========================================================================
  // State
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10,
    ST_DONE = 2'b11
  } lpsw_state_e;

  lpsw_state_e fsm_q;
  logic [7:0]  cmd_q;
  logic [3:0]  arb_q;
  logic        valid_q;
  logic        intDone_q;
  logic        memGate_q;
  logic        ctlGate_q;
  logic        autoGrant_q;
  logic        engReq_q;
  logic [4:0]  engTgt_q;
  logic        engExit_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  lpsw_cmd_if eng ();

  lpsw_engine #(.SEQ(lpsw_pkg::SEQ_CYCLES)) u_eng (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .cmd     (eng.eng)
  );

  assign eng.req    = engReq_q;
  assign eng.target = engTgt_q;
  assign eng.isExit = engExit_q;

  // ==========================================================================
  // Command decode
  function automatic logic [4:0] depth_of(input logic [7:0] c, input logic rows);
    logic [2:0] m;
    m = c[lpsw_pkg::CMD_MODE_MSB:lpsw_pkg::CMD_MODE_LSB];
    depth_of = lpsw_pkg::LP_NONE;
    if (m == lpsw_pkg::MODE_APD) begin
      depth_of = rows ? lpsw_pkg::LP_APD : lpsw_pkg::LP_PPD;
    end else if (m == lpsw_pkg::MODE_PPD) begin
      depth_of = lpsw_pkg::LP_PPD;
    end else if (m == lpsw_pkg::MODE_SR) begin
      if (c[lpsw_pkg::CMD_CCG_BIT] && c[lpsw_pkg::CMD_MCG_BIT]) begin
        depth_of = lpsw_pkg::LP_SR_CCG;
      end else if (c[lpsw_pkg::CMD_MCG_BIT]) begin
        depth_of = lpsw_pkg::LP_SR_MCG;
      end else begin
        depth_of = lpsw_pkg::LP_SR;
      end
    end
  endfunction

  wire [1:0] cmdDir   = cmd_q[lpsw_pkg::CMD_DIR_MSB:0];
  wire       cmdHold  = cmd_q[lpsw_pkg::CMD_LOCK_BIT];
  wire [4:0] curSt    = eng.curState;
  wire [4:0] reqDepth = depth_of(cmd_q, rowOpenS);
  wire       doExit   = (cmdDir == lpsw_pkg::DIR_EXIT) && (curSt != lpsw_pkg::LP_NONE);
  wire       doEntry  = (cmdDir == lpsw_pkg::DIR_ENTRY) && (reqDepth > curSt);
  wire       swOwns   = (arb_q == lpsw_pkg::ARB_SW) || (arb_q == lpsw_pkg::ARB_SW_LOCK);
  wire       canTake  = (arb_q == lpsw_pkg::ARB_IDLE) || swOwns;
  wire [3:0] swArb    = cmdHold ? lpsw_pkg::ARB_SW_LOCK : lpsw_pkg::ARB_SW;
  wire       autoCan  = (arb_q == lpsw_pkg::ARB_IDLE) || (arb_q == lpsw_pkg::ARB_AUTO);
  wire       autoWin  = autoReqS && (fsm_q == ST_IDLE) && autoCan;

  // ==========================================================================
  // Control machine
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fsm_q     <= ST_IDLE;
      cmd_q     <= 8'h00;
      arb_q     <= lpsw_pkg::ARB_IDLE;
      valid_q   <= 1'b1;
      intDone_q <= 1'b0;
      engReq_q  <= 1'b0;
      engTgt_q  <= lpsw_pkg::LP_NONE;
      engExit_q <= 1'b0;
      autoGrant_q <= 1'b0;
    end else begin
      engReq_q <= 1'b0;
      if (intWr && pwdata[lpsw_pkg::INT_DONE_BIT]) begin
        intDone_q <= 1'b0;
      end
      case (fsm_q)
        ST_IDLE: begin
          if (cmdWr) begin
            cmd_q <= pwdata[7:0];
            fsm_q <= ST_WAIT;
          end else if (autoWin) begin
            arb_q       <= lpsw_pkg::ARB_AUTO;
            autoGrant_q <= 1'b1;
          end else if (!autoReqS && arb_q == lpsw_pkg::ARB_AUTO) begin
            arb_q       <= lpsw_pkg::ARB_IDLE;
            autoGrant_q <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (!autoReqS && arb_q == lpsw_pkg::ARB_AUTO) begin
            arb_q       <= lpsw_pkg::ARB_IDLE;
            autoGrant_q <= 1'b0;
          end else if (canTake) begin
            if (!swOwns) begin
              arb_q <= swArb;
            end
            valid_q <= 1'b0;
            if (doExit || doEntry) begin
              engReq_q  <= 1'b1;
              engTgt_q  <= reqDepth;
              engExit_q <= doExit;
              fsm_q     <= ST_RUN;
            end else begin
              fsm_q <= ST_DONE;
            end
          end
        end
        ST_RUN: begin
          if (eng.done) begin
            fsm_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          valid_q   <= 1'b1;
          intDone_q <= 1'b1;
          arb_q     <= cmdHold ? lpsw_pkg::ARB_SW_LOCK : lpsw_pkg::ARB_IDLE;
          fsm_q     <= ST_IDLE;
        end
        default: fsm_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Clock gate outputs follow the reached state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      memGate_q <= 1'b0;
      ctlGate_q <= 1'b0;
    end else begin
      memGate_q <= (curSt == lpsw_pkg::LP_SR_MCG) || (curSt == lpsw_pkg::LP_SR_CCG);
      ctlGate_q <= (curSt == lpsw_pkg::LP_SR_CCG);
    end
  end

  // ==========================================================================
  // APB read path
  wire [31:0] stWord  = {26'h0, valid_q, curSt};
  wire [31:0] intWord = {22'h0, intDone_q, 9'h0};
  wire [31:0] ctlWord = {30'h0, rowOpenS, autoGrant_q};
  wire [31:0] rdMux   = hitCmd ? {24'h0, cmd_q} :
                        hitSt  ? stWord :
                        hitArb ? {28'h0, arb_q} :
                        hitInt ? intWord :
                        hitCtrl ? ctlWord : 32'h0;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !hitAny;
      prdata_q  <= (psel && !penable && !pwrite) ? rdMux : prdata_q;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign autoGrant  = autoGrant_q;
  assign memClkGate = memGate_q;
  assign ctlClkGate = ctlGate_q;

endmodule
`default_nettype wire

/* tb/lpsw_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module lpsw_top_checker (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        autoReq,
  input wire logic        autoGrant,
  input wire logic        memClkGate,
  input wire logic        ctlClkGate
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_ctl_gate_mem: assert property (ctlClkGate |-> memClkGate)
    else $error("controller gate alone");
  a_grant_drop: assert property ($fell(autoReq) |-> ##[1:6] !autoGrant)
    else $error("grant kept");
  a_grant_needs_req: assert property (!autoReq [*6] |-> !autoGrant)
    else $error("grant without request");
  a_gate_hold_auto: assert property (autoGrant && $past(autoGrant) |->
    $stable(memClkGate) && $stable(ctlClkGate))
    else $error("state change under automatic owner");
  c_refused: cover property (pready && pslverr);
  c_both_gated: cover property (ctlClkGate);
  c_auto_owner: cover property ($rose(autoGrant));
  c_mem_gated: cover property (memClkGate && !ctlClkGate);
endmodule
bind lpsw_top lpsw_top_checker u_chk (.clk_sys, .resetn, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .autoReq, .autoGrant, .memClkGate, .ctlClkGate);
`default_nettype wire

/* tb/lpsw_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lpsw_tb_top;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, se;
  logic        autoReq, rowOpen, autoGrant, memClkGate, ctlClkGate;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  int          errTotal, samplesChecked;
  // Row: cmd, rowOpen, depth, owner, memGate, ctlGate
  logic [19:0] rows [0:17] = '{
    {8'h02, 1'b1, 5'h01, 4'h0, 2'b00}, {8'h01, 1'b0, 5'h00, 4'h0, 2'b00},
    {8'h02, 1'b0, 5'h02, 4'h0, 2'b00}, {8'h0A, 1'b0, 5'h03, 4'h0, 2'b00},
    {8'h02, 1'b0, 5'h03, 4'h0, 2'b00}, {8'h2A, 1'b0, 5'h04, 4'h0, 2'b10},
    {8'h6A, 1'b0, 5'h05, 4'h0, 2'b11}, {8'h81, 1'b0, 5'h00, 4'h9, 2'b00},
    {8'h86, 1'b0, 5'h02, 4'h9, 2'b00}, {8'h80, 1'b0, 5'h02, 4'h9, 2'b00},
    {8'h8A, 1'b0, 5'h03, 4'h9, 2'b00}, {8'hAA, 1'b0, 5'h04, 4'h9, 2'b10},
    {8'hEA, 1'b0, 5'h05, 4'h9, 2'b11}, {8'h01, 1'b0, 5'h00, 4'h0, 2'b00},
    {8'h82, 1'b1, 5'h01, 4'h9, 2'b00}, {8'h06, 1'b0, 5'h02, 4'h0, 2'b00},
    {8'h01, 1'b0, 5'h00, 4'h0, 2'b00}, {8'h01, 1'b0, 5'h00, 4'h0, 2'b00}};

  lpsw_top DUT (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .autoReq, .rowOpen, .autoGrant, .memClkGate, .ctlClkGate);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========
  // Bus and compare tasks
  task automatic tallyAndFinish();
    $display("checked %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e) begin
      errTotal++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    d = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errTotal++;
      tallyAndFinish();
    end
  endtask

  task automatic waitState(input logic [4:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, lpsw_pkg::ADDR_STATE, 32'h0);
      n++;
    end while (d[5:0] !== {1'b1, e} && n < 60);
    chk(d & 32'h3F, {26'h0, 1'b1, e});
    if (d[5:0] !== {1'b1, e}) tallyAndFinish();
  endtask

  task automatic waitGrant(input logic e);
    int n;
    n = 0;
    while (autoGrant !== e && n < 30) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, autoGrant}, {31'h0, e});
    if (autoGrant !== e) tallyAndFinish();
  endtask

  // ==========
  // Sequence
  initial begin
    {psel, penable, pwrite, autoReq, rowOpen, paddr, pwdata} = '0;
    resetn = 1'b0;
    errTotal = 0;
    samplesChecked = 0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      rowOpen <= rows[i][11];
      apb(1'b1, lpsw_pkg::ADDR_CMD, {24'h0, rows[i][19:12]});
      apb(1'b0, lpsw_pkg::ADDR_STATE, 32'h0);
      chk(d & 32'h20, 32'h0);
      waitState(rows[i][10:6]);
      apb(1'b0, lpsw_pkg::ADDR_INT, 32'h0);
      chk(d & 32'h200, 32'h200);
      apb(1'b1, lpsw_pkg::ADDR_INT, 32'h200);
      apb(1'b0, lpsw_pkg::ADDR_ARB, 32'h0);
      chk(d, {28'h0, rows[i][5:2]});
      chk({30'h0, memClkGate, ctlClkGate}, {30'h0, rows[i][1:0]});
      $display("row %0d done", i);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, se}, 32'h1);
    chk(d, 32'h0);
    $display("test unmapped done");
    autoReq <= 1'b1;
    rowOpen <= 1'b1;
    waitGrant(1'b1);
    apb(1'b0, lpsw_pkg::ADDR_ARB, 32'h0);
    chk(d, 32'h3);
    apb(1'b0, lpsw_pkg::ADDR_CTRL, 32'h0);
    chk(d, 32'h3);
    apb(1'b1, lpsw_pkg::ADDR_CMD, 32'h02);
    repeat (20) @(posedge clk_sys);
    apb(1'b0, lpsw_pkg::ADDR_STATE, 32'h0);
    chk(d & 32'h1F, 32'h0);
    autoReq <= 1'b0;
    waitState(5'h01);
    $display("test pending done");
    apb(1'b1, lpsw_pkg::ADDR_CMD, 32'h80);
    waitState(5'h01);
    autoReq <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk({31'h0, autoGrant}, 32'h0);
    apb(1'b1, lpsw_pkg::ADDR_CMD, 32'h01);
    waitState(5'h00);
    apb(1'b0, lpsw_pkg::ADDR_CMD, 32'h0);
    chk(d, 32'h01);
    waitGrant(1'b1);
    autoReq <= 1'b0;
    waitGrant(1'b0);
    $display("test lock done");
    apb(1'b1, lpsw_pkg::ADDR_CMD, 32'h6A);
    waitState(5'h05);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({27'h0, pready, pslverr, autoGrant, memClkGate, ctlClkGate}, 32'h0);
    resetn <= 1'b1;
    apb(1'b0, lpsw_pkg::ADDR_ARB, 32'h0);
    chk(d, 32'h0);
    apb(1'b0, lpsw_pkg::ADDR_STATE, 32'h0);
    chk(d, 32'h20);
    $display("test reset done");
    tallyAndFinish();
  end
endmodule
`default_nettype wire
